//--- pkg/swf_pkg.sv
/*
  shared constants and state type of the sampler writeback formatter.
  assumes 256-bit general registers holding eight 32-bit dwords.
*/
package swf_pkg;
  localparam int unsigned REGW = 256;
  localparam int unsigned DESTW = 8;
  // writeback shapes, same coding as the request shape
  localparam logic [1:0] SH_S16 = 2'h0;
  localparam logic [1:0] SH_S8 = 2'h1;
  localparam logic [1:0] SH_S4X2 = 2'h2;
  localparam logic [1:0] SH_WIDE = 2'h3;
  // source registers per message, before compaction
  localparam logic [4:0] N_S16 = 5'h08;
  localparam logic [4:0] N_S8 = 5'h04;
  localparam logic [4:0] N_S4X2 = 5'h01;
  localparam logic [4:0] N_PK = 5'h08;
  localparam logic [4:0] N_PK_RG = 5'h04;
  localparam logic [4:0] N_BLK = 5'h10;
  localparam logic [4:0] KILL_IDX_RG = 5'h04;
  localparam logic [15:0] UNORM_MAX = 16'hff00;
  localparam logic [15:0] DISPATCH_ONES = 16'hffff;
  localparam logic [7:0] KILL_HI_ONES = 8'hff;
  localparam logic [7:0] KILL_DW_EN = 8'h01;
  // apb map
  localparam logic [11:0] A_CTRL = 12'h000;
  localparam logic [11:0] A_STAT = 12'h004;
  localparam logic [11:0] A_CNT = 12'h008;
  localparam logic CTRL_EN_RST = 1'b1;

  typedef enum logic [1:0] {ST_IDLE, ST_EMIT, ST_KILL} swf_st_t;

  typedef struct packed {
    swf_st_t st;
    logic [1:0] shp;
    logic blk;
    logic rg;
    logic kill;
    logic [3:0] cmask;
    logic [15:0] emask;
    logic [31:0] kmask;
    logic [7:0] dest;
    logic [4:0] k;
    logic [4:0] o;
    logic wv;
    logic wkill;
    logic [7:0] wreg;
    logic [255:0] wdat;
    logic [7:0] wen;
    logic en;
    logic [15:0] cnt;
    logic [31:0] prd;
  } swf_state_t;

  localparam swf_state_t SWF_RST = '{st: ST_IDLE, en: CTRL_EN_RST, default: '0};
endpackage : swf_pkg

//--- design/swf_writeback_formatter.sv
/*
  sampler writeback formatter: turns sampler result registers into the
  writeback register stream of one message, plus an apb control slave.
  assumes the sampler supplies every result register of a message in
  canonical order (uncompacted, packed shapes as 16 pixels of 16 bits in
  pixel order) and the thread side applies wb_dw_en per dword.
*/
// The placing of the registers and the APB register port were chosen for this implementation.
`timescale 1ns/100ps

// How it works
// - each request yields a writeback of the same shape it asked for
// - simd16 writeback has at most eight registers, two per channel, rgba order
// - simd16 masked channels are skipped and later channels shift down
// - simd16 dwords are written only where the execution mask bit is set
// - first register holds subspans 0 and 1, second holds subspans 2 and 3
// - 32-bit dwords pass unchanged in the surface's configured return format
// - simd8 always returns four channel registers, a fifth only for discard
// - simd8 masked channels keep their slot but write no dwords
// - discard register writes only dword 0, upper half all ones for simd8
// - simd8 active mask: low eight bits per pixel, upper eight forced one
// - simd4x2 is one register, sample 0 in dwords 0-3, sample 1 in 4-7
// - simd4x2 sample active if any of its four exec bits set
// - packed fetch pairs pixels per dword in the fixed pair order
// - packed values are clamped to the range 0000h to ff00h
// - two-channel packed fetch returns only red and green registers
// - packed discard register follows the channels, index 4 for two-channel
// - 32-bit active mask uses the fixed pixel-to-bit permutation
// - 64-pixel fetch returns up to sixteen registers, compacted
module swf_writeback_formatter (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic [1:0] req_shape,
  input wire logic req_block64,
  input wire logic req_two_chan,
  input wire logic req_kill,
  input wire logic [3:0] req_chan_mask,
  input wire logic [15:0] req_exec_mask,
  input wire logic [31:0] req_kill_pix,
  input wire logic [swf_pkg::DESTW-1:0] req_dest,
  input wire logic src_valid,
  output logic src_ready,
  input wire logic [swf_pkg::REGW-1:0] src_data,
  output logic wb_valid,
  input wire logic wb_ready,
  output logic [swf_pkg::DESTW-1:0] wb_reg,
  output logic [swf_pkg::REGW-1:0] wb_data,
  output logic [7:0] wb_dw_en
);
  import swf_pkg::*;

  swf_state_t q;
  swf_state_t next_q;

  logic slot_free;
  logic [4:0] nsrc;
  logic [1:0] ch;
  logic skip;
  logic [255:0] pk_data;
  logic [31:0] kill_perm;
  logic [7:0] en4x2;
  logic [255:0] fmt_data;
  logic [7:0] fmt_en;
  logic [31:0] kill_dw;
  logic a_ctrl;
  logic a_stat;
  logic a_cnt;

  function automatic logic [15:0] clamp_unorm(input logic [15:0] v);
    clamp_unorm = (v > UNORM_MAX) ? UNORM_MAX : v;
  endfunction : clamp_unorm

  // registers a message returns before any discard register, from shape, block/two-channel flags and channel mask
  function automatic logic [4:0] chan_regs(input logic [1:0] shp, input logic blk,
                                           input logic rg, input logic [3:0] cmask);
    case (shp)
      SH_S16: chan_regs = 5'(2 * (4 - $countones(cmask)));
      SH_S8: chan_regs = N_S8;
      SH_S4X2: chan_regs = N_S4X2;
      default: begin
        if (blk) begin
          chan_regs = 5'(4 * (4 - $countones(cmask)));
        end else if (rg) begin
          chan_regs = 5'(2 * (2 - $countones(cmask[1:0])));
        end else begin
          chan_regs = 5'(2 * (4 - $countones(cmask)));
        end
      end
    endcase
  endfunction : chan_regs

  // packed layout: dword d holds pixels lo and lo+1 of a 16-pixel half
  genvar gd;
  generate
    for (gd = 0; gd < 8; gd++) begin : g_pack
      localparam int LO = ((gd % 2) * 2) + (((gd / 2) % 2) * 8) + ((gd / 4) * 4);
      assign pk_data[32*gd +: 32] = {clamp_unorm(src_data[16*(LO+1) +: 16]),
                                     clamp_unorm(src_data[16*LO +: 16])};
      assign en4x2[gd] = (|q.emask[4*(gd/4) +: 4]) & ~q.cmask[gd % 4];
    end
  endgenerate

  // pixel p at row r, column c lands on its permuted mask bit
  genvar gp;
  generate
    for (gp = 0; gp < 32; gp++) begin : g_kill
      localparam int R = gp / 8;
      localparam int C = gp % 8;
      localparam int B = (C % 2) + ((R % 2) * 2) + (((C / 2) % 2) * 4)
                         + ((R / 2) * 8) + ((C / 4) * 16);
      assign kill_perm[B] = ~q.kmask[gp];
    end
  endgenerate

  assign slot_free = !q.wv || wb_ready;
  assign req_ready = (q.st == ST_IDLE) && q.en;
  assign src_ready = (q.st == ST_EMIT) && slot_free;
  assign wb_valid = q.wv;
  assign wb_reg = q.wreg;
  assign wb_data = q.wdat;
  assign wb_dw_en = q.wen;
  assign prdata = q.prd;
  // zero wait states: every access completes in its first access cycle
  assign pready = 1'b1;
  assign a_ctrl = (paddr == A_CTRL);
  assign a_stat = (paddr == A_STAT);
  assign a_cnt = (paddr == A_CNT);
  assign pslverr = psel && penable && !(a_ctrl || a_stat || a_cnt);

  always_comb begin
    case (q.shp)
      SH_S16: nsrc = N_S16;
      SH_S8: nsrc = N_S8;
      SH_S4X2: nsrc = N_S4X2;
      default: nsrc = q.blk ? N_BLK : (q.rg ? N_PK_RG : N_PK);
    endcase
    case (q.shp)
      SH_S8: ch = q.k[1:0];
      SH_S4X2: ch = 2'h0;
      default: ch = q.k[2:1];
    endcase
    // simd16 and wide fetches compact; simd8 keeps the slot
    skip = ((q.shp == SH_S16) || (q.shp == SH_WIDE)) && q.cmask[ch];
    case (q.shp)
      SH_S16: begin
        fmt_data = src_data;
        fmt_en = q.k[0] ? q.emask[15:8] : q.emask[7:0];
      end
      SH_S8: begin
        fmt_data = src_data;
        fmt_en = q.cmask[ch] ? 8'h00 : q.emask[7:0];
      end
      SH_S4X2: begin
        fmt_data = src_data;
        fmt_en = en4x2;
      end
      default: begin
        fmt_data = pk_data;
        fmt_en = 8'hff;
      end
    endcase
    if (q.shp == SH_S8) begin
      kill_dw = {DISPATCH_ONES, KILL_HI_ONES, ~q.kmask[7:0]};
    end else begin
      kill_dw = kill_perm;
    end
  end

  always_comb begin
    next_q = q;
    if (q.wv && wb_ready) begin
      next_q.wv = 1'b0;
    end
    // read data is caught in the setup cycle and shown in the access cycle
    if (psel && !penable) begin
      if (a_ctrl) begin
        next_q.prd = {31'h0000_0000, q.en};
      end else if (a_stat) begin
        next_q.prd = {28'h000_0000, q.st, q.wv, q.st != ST_IDLE};
      end else if (a_cnt) begin
        next_q.prd = {16'h0000, q.cnt};
      end else begin
        next_q.prd = 32'h0000_0000;
      end
    end
    if (psel && penable && pwrite && a_ctrl) begin
      next_q.en = pwdata[0];
    end
    case (q.st)
      ST_IDLE: begin
        if (req_valid && req_ready) begin
          next_q.st = ST_EMIT;
          next_q.shp = req_shape;
          next_q.blk = req_block64;
          next_q.rg = req_two_chan && !req_block64;
          // only simd8 and 32-pixel packed fetches have a discard variant
          next_q.kill = req_kill && ((req_shape == SH_S8)
                        || ((req_shape == SH_WIDE) && !req_block64));
          next_q.cmask = req_chan_mask;
          next_q.emask = req_exec_mask;
          next_q.kmask = req_kill_pix;
          next_q.dest = req_dest;
          next_q.k = 5'h00;
          next_q.o = 5'h00;
        end
      end
      ST_EMIT: begin
        if (src_valid && src_ready) begin
          if (!skip) begin
            next_q.wv = 1'b1;
            next_q.wkill = 1'b0;
            next_q.wreg = q.dest + {3'h0, q.o};
            next_q.wdat = fmt_data;
            next_q.wen = fmt_en;
            next_q.o = q.o + 5'h01;
          end
          next_q.k = q.k + 5'h01;
          if (q.k == nsrc - 5'h01) begin
            next_q.st = q.kill ? ST_KILL : ST_IDLE;
            if (!q.kill) begin
              next_q.cnt = q.cnt + 16'h0001;
            end
          end
        end
      end
      ST_KILL: begin
        if (slot_free) begin
          next_q.wv = 1'b1;
          next_q.wkill = 1'b1;
          // two-channel index is fixed; otherwise right after the last channel
          next_q.wreg = q.dest + {3'h0, q.rg ? KILL_IDX_RG : q.o};
          next_q.wdat = {224'h0, kill_dw};
          next_q.wen = KILL_DW_EN;
          next_q.st = ST_IDLE;
          next_q.cnt = q.cnt + 16'h0001;
        end
      end
      default: next_q.st = ST_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= SWF_RST;
    end else begin
      q <= next_q;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_s16_bound: assert property (q.wv && q.shp == SH_S16 |->
    (q.wreg - q.dest) < 8'h08 && !q.wkill)
    else $error("simd16 writeback beyond eight registers");

  // pairs survive compaction whole, so register parity tells the subspan half
  chk_s16_exec: assert property (q.wv && q.shp == SH_S16 |->
    q.wen == ((q.wreg[0] != q.dest[0]) ? q.emask[15:8] : q.emask[7:0]))
    else $error("simd16 dword enables do not follow exec mask half");

  chk_s16_compact: assert property (q.wv && q.shp == SH_S16 && !q.wkill |->
    (q.wreg - q.dest) < {3'h0, chan_regs(q.shp, q.blk, q.rg, q.cmask)})
    else $error("simd16 register beyond compacted channels");

  chk_s8_slot: assert property (q.wv && q.shp == SH_S8 && !q.wkill |->
    q.wen == (q.cmask[2'(q.wreg - q.dest)] ? 8'h00 : q.emask[7:0]))
    else $error("simd8 channel enables wrong");

  chk_kill_dword: assert property (q.wv && q.wkill |->
    q.wen == 8'h01 && (q.shp != SH_S8 || q.wdat[31:8] == 24'hff_ffff))
    else $error("discard register layout wrong");

  chk_s4x2_one: assert property (q.wv && q.shp == SH_S4X2 |->
    q.wreg == q.dest && (|q.emask[3:0] || q.wen[3:0] == 4'h0))
    else $error("simd4x2 register or inactive sample wrong");

  chk_unorm_clamp: assert property (q.wv && q.shp == SH_WIDE && !q.wkill |->
    q.wdat[15:0] <= UNORM_MAX && q.wdat[31:16] <= UNORM_MAX)
    else $error("packed value above full scale");

  chk_rg_count: assert property (q.wv && q.shp == SH_WIDE && q.rg |->
    (q.wkill ? q.wreg == q.dest + 8'h04 : (q.wreg - q.dest) < 8'h04))
    else $error("two-channel fetch register index wrong");

  chk_wide_bound: assert property (q.wv && q.shp == SH_WIDE |->
    (q.wreg - q.dest) < 8'h10)
    else $error("wide writeback beyond sixteen registers");

  chk_reg_ascend: assert property (q.wv && wb_ready ##1 q.wv && q.st != ST_IDLE |->
    q.wreg == $past(q.wreg) + 8'h01)
    else $error("writeback registers not ascending");

  chk_hold_stall: assert property (q.wv && !wb_ready |=>
    q.wv && $stable(q.wreg) && $stable(q.wdat) && $stable(q.wen))
    else $error("writeback changed while stalled");

  chk_req_shape: assert property (req_valid && req_ready |=>
    q.shp == $past(req_shape) && q.st == ST_EMIT)
    else $error("request shape not taken");

  chk_shape_hold: assert property (q.st != ST_IDLE |=>
    $stable(q.shp))
    else $error("shape changed inside a message");

  chk_msg_length: assert property (src_valid && src_ready && q.k == nsrc - 5'h01 |=>
    q.o == chan_regs(q.shp, q.blk, q.rg, q.cmask))
    else $error("message returned wrong register count");

  chk_s8_count: assert property (q.wv && q.shp == SH_S8 && !q.wkill |->
    (q.wreg - q.dest) < 8'h04)
    else $error("simd8 channel register out of range");

  chk_s8_kill_idx: assert property (q.wv && q.wkill && q.shp == SH_S8 |->
    q.wreg == q.dest + 8'h04)
    else $error("simd8 discard register not fifth");

  chk_s8_pixmask: assert property (q.wv && q.wkill && q.shp == SH_S8 |->
    q.wdat[15:0] == {8'hff, ~q.kmask[7:0]})
    else $error("simd8 active pixel mask wrong");

  chk_s4x2_sample: assert property (q.wv && q.shp == SH_S4X2 |->
    (|q.emask[7:4] || q.wen[7:4] == 4'h0) && (q.wen[3:0] & q.cmask) == 4'h0
    && (q.wen[7:4] & q.cmask) == 4'h0)
    else $error("simd4x2 sample or channel enable wrong");

  chk_pack_kill_idx: assert property (q.wv && q.wkill && q.shp == SH_WIDE |->
    (q.wreg - q.dest) == (q.rg ? 8'h04 : {3'h0, chan_regs(q.shp, q.blk, q.rg, q.cmask)}))
    else $error("packed discard register index wrong");

  chk_wide_full: assert property (q.wv && q.shp == SH_WIDE |->
    q.wen == (q.wkill ? 8'h01 : 8'hff))
    else $error("wide writeback dword enables wrong");

  chk_kill_variant: assert property (q.wv && q.wkill |->
    !q.blk && (q.shp == SH_S8 || q.shp == SH_WIDE))
    else $error("discard register on a shape without discard");

  chk_kill_once: assert property (q.wv && q.wkill && wb_ready |=>
    !q.wv)
    else $error("register follows the discard register");

  chk_data_pass: assert property (src_valid && src_ready && !skip && q.shp != SH_WIDE |=>
    q.wdat == $past(src_data))
    else $error("32-bit result not passed unchanged");

  // pixel 8 sits low in dword 2, pixel 4 low in dword 4
  chk_pack_pairs: assert property (src_valid && src_ready && !skip && q.shp == SH_WIDE |=>
    (q.wdat[79:64] == (($past(src_data[143:128]) > UNORM_MAX) ? UNORM_MAX : $past(src_data[143:128])))
    && (q.wdat[143:128] == (($past(src_data[79:64]) > UNORM_MAX) ? UNORM_MAX : $past(src_data[79:64]))))
    else $error("packed pixel pair order wrong");

  chk_busy_refuse: assert property (q.st != ST_IDLE || !q.en |->
    !req_ready)
    else $error("request accepted while busy or disabled");

  chk_src_stall: assert property (q.wv && !wb_ready |->
    !src_ready)
    else $error("source taken while output slot full");

  chk_idle_src: assert property (q.st != ST_EMIT |->
    !src_ready)
    else $error("source taken outside a message");

  cov_s16_mask: cover property (q.wv && q.shp == SH_S16 && q.cmask != 4'h0);
  cov_s4x2_hi: cover property (q.wv && q.shp == SH_S4X2 && q.wen[7:4] != 4'h0);
  cov_s8_kill: cover property (q.wv && q.wkill && q.shp == SH_S8);
  cov_rg_kill: cover property (q.wv && q.wkill && q.rg);
  cov_blk64: cover property (q.wv && q.blk && (q.wreg - q.dest) == 8'h0f);
endmodule : swf_writeback_formatter

//--- bench/swf_thread_model.sv
/*
  thread-side model: accepts writeback registers and merges them into a
  general register file by dword enable.
  assumes the formatter's single pclk domain.
*/
`timescale 1ns/100ps
module swf_thread_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic slow,
  input wire logic wb_valid,
  output logic wb_ready,
  input wire logic [7:0] wb_reg,
  input wire logic [255:0] wb_data,
  input wire logic [7:0] wb_dw_en
);
  logic [255:0] grf [256];
  logic ph;
  // stalls every other cycle when slow so the output slot backs up
  assign wb_ready = !slow || ph;
  initial begin
    for (int i = 0; i < 256; i++) grf[i] = {8{32'h5a5a_5a5a}};
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) ph <= 1'b0;
    else ph <= !ph;
  end
  always @(posedge pclk) begin
    if (wb_valid && wb_ready) begin
      for (int d = 0; d < 8; d++) if (wb_dw_en[d]) grf[wb_reg][32*d +: 32] <= wb_data[32*d +: 32];
    end
  end
endmodule : swf_thread_model

//--- bench/testbench.sv
/*
  self-checking bench of the writeback formatter: apb and message tasks,
  results checked in the thread model's register file.
  assumes the swf_pkg constants and the thread model beside it.
*/
`timescale 1ns/100ps
module testbench;
  import swf_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, slow = 0, er;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic pready, pslverr, req_ready, src_ready, wb_valid, wb_ready;
  logic req_valid = 0, req_block64 = 0, req_two_chan = 0, req_kill = 0, src_valid = 0;
  logic [1:0] req_shape = '0;
  logic [3:0] req_chan_mask = '0;
  logic [15:0] req_exec_mask = '0;
  logic [31:0] req_kill_pix = '0;
  logic [7:0] req_dest = '0, wb_reg, wb_dw_en;
  logic [255:0] src_data = '0, wb_data;
  int bad_count = 0, compares = 0, cyc = 0;
  localparam logic [31:0] FILL = 32'h5a5a_5a5a;
  int lo_tbl [8] = '{0, 2, 8, 10, 4, 6, 12, 14};
  int bit_tbl [32] = '{0, 1, 4, 5, 16, 17, 20, 21, 2, 3, 6, 7, 18, 19, 22, 23,
                       8, 9, 12, 13, 24, 25, 28, 29, 10, 11, 14, 15, 26, 27, 30, 31};
  always #4 pclk = ~pclk;
  swf_writeback_formatter DUT (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata,
    .prdata, .pready, .pslverr, .req_valid, .req_ready, .req_shape, .req_block64,
    .req_two_chan, .req_kill, .req_chan_mask, .req_exec_mask, .req_kill_pix, .req_dest,
    .src_valid, .src_ready, .src_data, .wb_valid, .wb_ready, .wb_reg, .wb_data, .wb_dw_en);
  swf_thread_model PART (.pclk, .presetn, .slow, .wb_valid, .wb_ready, .wb_reg, .wb_data,
    .wb_dw_en);
  function automatic logic [15:0] raw(int k, int i);
    // one pixel above full scale to exercise the clamp
    return (k == 0 && i == 1) ? 16'hffff : {k[3:0], i[3:0], 8'h00};
  endfunction : raw
  function automatic logic [15:0] px(int k, int i);
    return (raw(k, i) > UNORM_MAX) ? UNORM_MAX : raw(k, i);
  endfunction : px
  function automatic logic [31:0] s32(int k, int d);
    return {8'hc0, k[7:0], 8'h00, d[7:0]};
  endfunction : s32
  function automatic logic [31:0] pkd(int k, int d);
    return {px(k, lo_tbl[d] + 1), px(k, lo_tbl[d])};
  endfunction : pkd
  function automatic logic [255:0] srcreg(int k, logic pk);
    for (int i = 0; i < 16; i++) srcreg[16*i +: 16] = pk ? raw(k, i) : s32(k, i / 2) >> (16 * (i % 2));
  endfunction : srcreg
  function automatic logic [31:0] dw(int r, int d);
    return PART.grf[r][32*d +: 32];
  endfunction : dw
  task automatic chk(input logic [31:0] g, e);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] d, output logic e);
    @(posedge pclk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, wd};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    d = prdata;
    e = pslverr;
    {psel, penable} <= 2'b00;
  endtask : apb
  task automatic msg(input logic [1:0] sh, input logic b64, rg, kl, input logic [3:0] cm,
                     input logic [15:0] ex, input logic [31:0] kp, input logic [7:0] ds, input int ns);
    @(posedge pclk);
    req_valid <= 1'b1;
    {req_shape, req_block64, req_two_chan, req_kill} <= {sh, b64, rg, kl};
    {req_chan_mask, req_exec_mask, req_kill_pix, req_dest} <= {cm, ex, kp, ds};
    do @(posedge pclk); while (req_ready !== 1'b1);
    req_valid <= 1'b0;
    for (int k = 0; k < ns; k++) begin
      src_valid <= 1'b1;
      src_data <= srcreg(k, sh == SH_WIDE);
      do @(posedge pclk); while (src_ready !== 1'b1);
    end
    src_valid <= 1'b0;
    repeat (3) @(posedge pclk);
    while (!(req_ready === 1'b1 && wb_valid === 1'b0)) @(posedge pclk);
    @(posedge pclk);
  endtask : msg
  // walks source order, skipping masked channels, so r ends as the count emitted
  task automatic chk_cmp(input int ds, ns, input logic [3:0] cm, input logic pk,
                         input logic [15:0] ex, output int r);
    r = 0;
    for (int k = 0; k < ns; k++) if (!cm[(k / 2) % 4]) begin
      for (int d = 0; d < 8; d++)
        chk(dw(ds + r, d), ex[8 * (k % 2) + d] ? (pk ? pkd(k, d) : s32(k, d)) : FILL);
      r++;
    end
    chk(dw(ds + r, 1), FILL);
  endtask : chk_cmp
  task automatic end_sim;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_sim
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 3000) begin
      bad_count++;
      end_sim();
    end
  end
  initial begin
    int r;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, A_CTRL, '0, rd, er);
    chk(rd, 32'h0000_0001);
    apb(1'b0, 12'h00c, '0, rd, er);
    chk({rd[31:1], er}, 32'h0000_0001);
    apb(1'b1, A_CTRL, '0, rd, er);
    @(posedge pclk);
    chk({31'h0, req_ready}, '0);
    apb(1'b1, A_CTRL, 32'h0000_0001, rd, er);
    $display("test apb done");
    slow <= 1'b1;
    msg(SH_S16, 0, 0, 0, 4'b0110, 16'h0ff0, '0, 8'h10, 8);
    chk_cmp(16, 8, 4'b0110, 0, 16'h0ff0, r);
    chk(r, 4);
    $display("test simd16 done");
    msg(SH_S8, 0, 0, 1, 4'b0010, 16'h005a, 32'h0000_0005, 8'h20, 4);
    for (int c = 0; c < 4; c++) for (int d = 0; d < 8; d++)
      chk(dw(32 + c, d), (!req_chan_mask[c] && req_exec_mask[d]) ? s32(c, d) : FILL);
    chk(dw(36, 0), {16'hffff, 8'hff, ~8'h05});
    chk(dw(36, 1), FILL);
    $display("test simd8 done");
    msg(SH_S4X2, 0, 0, 0, 4'b1001, 16'h0010, '0, 8'h30, 1);
    for (int d = 0; d < 8; d++)
      chk(dw(48, d), (req_exec_mask[4 * (d / 4) +: 4] != 0 && !req_chan_mask[d % 4]) ?
          s32(0, d) : FILL);
    $display("test simd4x2 done");
    for (int t = 0; t < 2; t++) begin
      msg(SH_WIDE, 0, t[0], 1, t ? 4'b0000 : 4'b0010, '1, 32'h8001_0021,
          t ? 8'h50 : 8'h40, t ? 4 : 8);
      chk_cmp(64 + 16 * t, t ? 4 : 8, req_chan_mask, 1, '1, r);
      chk(r, t ? 4 : 6);
      for (int p = 0; p < 32; p++)
        chk((dw(64 + 16 * t + r, 0) >> bit_tbl[p]) & 32'h1, !req_kill_pix[p]);
    end
    $display("test packed done");
    msg(SH_WIDE, 1, 0, 0, 4'b0100, '1, '0, 8'h60, 16);
    chk_cmp(96, 16, 4'b0100, 1, '1, r);
    chk(r, 12);
    apb(1'b0, A_CNT, '0, rd, er);
    chk(rd, 32'h0000_0006);
    $display("test block64 done");
    end_sim();
  end
endmodule : testbench
